// *** hdl/ipo_consts.svh ***
// Purpose: named constants for the prefetch and overlap timing block
// Assumes: included by bare name from the design file
// Notes: ea cost words pack head[15:12] tail[11:8] cycles[7:3] x_read[2] fetches[1:0]
`ifndef IPO_CONSTS_SVH
`define IPO_CONSTS_SVH

// ----------------------------------------------------------------
// base bus and queue figures
// ----------------------------------------------------------------
`define IPO_BASE_BUS_CLKS 4'h2
`define IPO_SLOW_BUS_CLKS 4'h4
`define IPO_QUEUE_MIN 2'h2
`define IPO_QUEUE_MAX 2'h3
`define IPO_QUEUE_RESET 2'h2
`define IPO_BRANCH_MIN_FETCH 4'h3
`define IPO_DISP_DELAY 10'sh001
`define IPO_EXT_WAIT 10'sh001
`define IPO_LONG_EXTRA 10'sh002
`define IPO_COF_SPARE_CLKS 4'h2
`define IPO_READS_WORD 4'h1
`define IPO_READS_LONG 4'h2

// ----------------------------------------------------------------
// effective-address fetch cost words, word-sized operand
// ----------------------------------------------------------------
`define IPO_EA_NONE 16'h0000
`define IPO_EA_IND 16'h111c
`define IPO_EA_PREDEC 16'h2224
`define IPO_EA_DISP16 16'h132d
`define IPO_EA_ABS_LONG 16'h153e
`define IPO_EA_IMM_WORD 16'h1119
`define IPO_EA_IMM_LONG 16'h132a
`define IPO_EA_INDEX8 16'h4245

// ----------------------------------------------------------------
// cost word field positions
// ----------------------------------------------------------------
`define IPO_F_HEAD 15:12
`define IPO_F_TAIL 11:8
`define IPO_F_CYC 7:3
`define IPO_F_XRD 2
`define IPO_F_FETCH 1:0

`endif

// *** hdl/ipo_pkg.sv ***
// Purpose: types shared by the prefetch and overlap timing block
// Assumes: nothing beyond the constants header
// Notes: mode codes are free; only their names matter
package ipo_pkg;

  // ----------------------------------------------------------------
  // operand location modes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IPO_DATA_REGISTER_DIRECT,
    IPO_ADDRESS_REGISTER_DIRECT,
    IPO_IND,
    IPO_POSTINC,
    IPO_PREDEC,
    IPO_DISP16,
    IPO_ABS_WORD,
    IPO_ABS_LONG,
    IPO_IMM_BYTE,
    IPO_IMM_WORD,
    IPO_IMM_LONG,
    IPO_INDEX8
  } ipo_operand_location_t;

  // ----------------------------------------------------------------
  // operand sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IPO_SIZE_BYTE,
    IPO_SIZE_WORD,
    IPO_SIZE_LONG
  } ipo_size_t;

endpackage

// *** hdl/ipo_timing.sv ***
// Purpose: per-instruction overlap, prefetch and access-count timing engine
// Assumes: one instruction descriptor per i_issue pulse, same-clock source
// Notes: results registered one clock after i_issue, marked by o_done
//   negative tails give no overlap; fewer than two clocks per access is unsupported
`timescale 1ns/10ps
`default_nettype none
`include "ipo_consts.svh"

module ipo_timing (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // instruction descriptor, sampled on the issue edge
  input wire logic i_issue,
  input wire logic [3:0] i_operand_location,
  input wire logic [1:0] i_size,
  input wire logic [3:0] i_op_head,
  input wire logic signed [4:0] i_op_tail,
  input wire logic [5:0] i_op_cycles,
  input wire logic [1:0] i_op_reads,
  input wire logic [1:0] i_op_fetches,
  input wire logic [1:0] i_op_writes,
  input wire logic i_change_of_flow,
  input wire logic i_taken,
  input wire logic i_needs_ext,
  input wire logic [3:0] i_bus_clks,
  // registered results, held until the next issue; o_done only for the clock after it
  output logic o_done,
  output logic [3:0] o_head,
  output logic signed [9:0] o_tail,
  output logic [9:0] o_cycles,
  output logic [3:0] o_overlap,
  output logic [9:0] o_attributed,
  output logic [3:0] o_reads,
  output logic [3:0] o_fetches,
  output logic [3:0] o_writes,
  output logic [3:0] o_spare_clks,
  output logic o_prefetch_early,
  output logic o_prefetch_deferred,
  output logic o_ext_wait,
  output logic [1:0] o_queue_words,
  // running sums since reset
  output logic [15:0] o_total_clks,
  output logic [15:0] o_total_reads,
  output logic [15:0] o_total_fetches,
  output logic [15:0] o_total_writes
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // fetch cost of an operand location, word-sized
  function automatic logic [15:0] ea_cost(input logic [3:0] loc);
    case (loc)
      ipo_pkg::IPO_DATA_REGISTER_DIRECT: ea_cost = `IPO_EA_NONE;
      ipo_pkg::IPO_ADDRESS_REGISTER_DIRECT: ea_cost = `IPO_EA_NONE;
      ipo_pkg::IPO_IND: ea_cost = `IPO_EA_IND;
      ipo_pkg::IPO_POSTINC: ea_cost = `IPO_EA_IND;
      ipo_pkg::IPO_PREDEC: ea_cost = `IPO_EA_PREDEC;
      ipo_pkg::IPO_DISP16: ea_cost = `IPO_EA_DISP16;
      ipo_pkg::IPO_ABS_WORD: ea_cost = `IPO_EA_DISP16;
      ipo_pkg::IPO_ABS_LONG: ea_cost = `IPO_EA_ABS_LONG;
      ipo_pkg::IPO_IMM_BYTE: ea_cost = `IPO_EA_IMM_WORD;
      ipo_pkg::IPO_IMM_WORD: ea_cost = `IPO_EA_IMM_WORD;
      ipo_pkg::IPO_IMM_LONG: ea_cost = `IPO_EA_IMM_LONG;
      ipo_pkg::IPO_INDEX8: ea_cost = `IPO_EA_INDEX8;
      default: ea_cost = `IPO_EA_NONE;
    endcase
  endfunction

  // word-sized extension words that must age in the queue; long ones do not
  function automatic logic ext_mode(input logic [3:0] loc);
    ext_mode = (loc == ipo_pkg::IPO_DISP16) || (loc == ipo_pkg::IPO_ABS_WORD) ||
               (loc == ipo_pkg::IPO_IMM_WORD) || (loc == ipo_pkg::IPO_IMM_BYTE);
  endfunction

  // smaller of two non-negative clock counts
  function automatic logic signed [9:0] min_clks(input logic signed [9:0] a,
                                                 input logic signed [9:0] b);
    min_clks = (a < b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // state carried between instructions
  // ----------------------------------------------------------------
  logic signed [9:0] prev_tail;
  logic [1:0] queue_words;

  // ----------------------------------------------------------------
  // per-instruction cost, combinational from the descriptor
  // ----------------------------------------------------------------
  // operand location piece
  logic [15:0] cost;
  logic is_long;
  logic ea_used;
  logic signed [9:0] ea_head;
  logic signed [9:0] ea_tail;
  logic signed [9:0] ea_cyc;
  logic [3:0] ea_reads;
  // operation piece
  logic signed [9:0] op_head;
  logic signed [9:0] op_tail;
  logic signed [9:0] op_cyc;
  logic [3:0] op_wr;
  // joined timing and access counts
  logic signed [9:0] next_head;
  logic signed [9:0] base_tail;
  logic signed [9:0] base_cyc;
  logic [3:0] next_reads;
  logic [3:0] next_fetches;
  logic [3:0] accesses;
  logic signed [9:0] wait_clks;
  logic signed [9:0] next_tail;
  logic signed [9:0] next_cyc;
  // overlap and prefetch placement
  logic signed [9:0] next_overlap;
  logic next_ext_wait;
  logic next_early;
  logic next_deferred;
  logic [3:0] next_spare;
  logic [1:0] next_queue;
  logic branch_taken;

  // operand location part, widened for long operands
  always_comb begin
    cost = ea_cost(i_operand_location);
    is_long = (i_size == ipo_pkg::IPO_SIZE_LONG);
    ea_used = (cost != `IPO_EA_NONE);
    ea_head = 10'(cost[`IPO_F_HEAD]);
    ea_tail = 10'(cost[`IPO_F_TAIL]);
    ea_cyc = 10'(cost[`IPO_F_CYC]);
    ea_reads = 4'h0;
    if (cost[`IPO_F_XRD]) begin
      ea_reads = is_long ? `IPO_READS_LONG : `IPO_READS_WORD;
      if (is_long) begin
        ea_tail = ea_tail + `IPO_LONG_EXTRA;
        ea_cyc = ea_cyc + `IPO_LONG_EXTRA;
      end
    end
  end

  // operation part; a long trailing write doubles its bus cycles
  always_comb begin
    op_head = 10'(i_op_head);
    op_tail = 10'(i_op_tail);
    op_cyc = 10'(i_op_cycles);
    op_wr = 4'(i_op_writes);
    if (is_long && (i_op_writes != 2'h0)) begin
      op_wr = 4'({i_op_writes, 1'b0});
      op_tail = op_tail + `IPO_LONG_EXTRA;
      op_cyc = op_cyc + `IPO_LONG_EXTRA;
    end
  end

  // join location and operation as two overlapping pieces
  always_comb begin
    branch_taken = i_change_of_flow && i_taken;
    if (ea_used) begin
      // a zero operation head gives a zero min, so the read time adds serially
      base_cyc = ea_cyc - min_clks(ea_tail, op_head) + op_cyc;
      next_head = ea_head;
    end else begin
      base_cyc = op_cyc;
      next_head = op_head;
    end
    base_tail = op_tail;
    next_reads = ea_reads + 4'(i_op_reads);
    // a branch fetches only its own words, yet a taken one's internal delay forces three
    next_fetches = 4'(cost[`IPO_F_FETCH]) + 4'(i_op_fetches);
    if (branch_taken && (next_fetches < `IPO_BRANCH_MIN_FETCH)) begin
      next_fetches = `IPO_BRANCH_MIN_FETCH;
    end
    accesses = next_reads + next_fetches + op_wr;
  end

  // bus speed adjustment; change of flow uses the negative-tail form
  always_comb begin
    wait_clks = 10'(i_bus_clks) - 10'(`IPO_BASE_BUS_CLKS);
    next_tail = base_tail;
    next_cyc = base_cyc;
    if (i_change_of_flow) begin
      next_tail = base_tail + wait_clks;
      // beyond four clocks per access the refill costs once more per extra clock
      if (i_bus_clks > `IPO_SLOW_BUS_CLKS) begin
        next_cyc = base_cyc + wait_clks + (10'(i_bus_clks) - 10'(`IPO_SLOW_BUS_CLKS));
      end else begin
        next_cyc = base_cyc + wait_clks;
      end
    end else begin
      // every access of this instruction stretches by the wait states
      next_cyc = base_cyc + 10'(wait_clks * 10'(accesses));
    end
    if (branch_taken) begin
      next_cyc = next_cyc + `IPO_DISP_DELAY;
    end
    // extension word just arrived unless the queue already ran ahead
    next_ext_wait = (ext_mode(i_operand_location) || i_needs_ext) &&
                    (queue_words < `IPO_QUEUE_MAX);
    if (next_ext_wait) begin
      next_cyc = next_cyc + `IPO_EXT_WAIT;
    end
  end

  // overlap with the previous instruction and prefetch placement
  always_comb begin
    // negative tails count as zero overlap
    if (prev_tail > 10'sh000) begin
      next_overlap = min_clks(prev_tail, next_head);
    end else begin
      next_overlap = 10'sh000;
    end
    next_early = (prev_tail < 10'sh000);
    // a trailing write that fills the whole head pushes the refill later
    next_deferred = (prev_tail > 10'sh000) && (prev_tail >= next_head);
    // spare refill clocks exist only while the bus keeps pace with the sequencer
    if (i_change_of_flow && (i_bus_clks == `IPO_BASE_BUS_CLKS)) begin
      next_spare = `IPO_COF_SPARE_CLKS;
    end else begin
      next_spare = 4'h0;
    end
    // new path restarts at the minimum, spare clocks may add the third word
    if (branch_taken) begin
      next_queue = (next_spare != 4'h0) ? `IPO_QUEUE_MAX : `IPO_QUEUE_MIN;
    end else if (next_tail <= 10'sh000) begin
      next_queue = `IPO_QUEUE_MAX;
    end else begin
      next_queue = `IPO_QUEUE_MIN;
    end
  end

  // ----------------------------------------------------------------
  // carried state
  // ----------------------------------------------------------------

  // tail of the last instruction feeds the next overlap
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_tail <= 10'sh000;
    end else if (i_issue) begin
      prev_tail <= next_tail;
    end
  end

  // queue occupancy; pipeline starts at the two-word minimum, one word short of full
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      queue_words <= `IPO_QUEUE_RESET;
    end else if (i_issue) begin
      queue_words <= next_queue;
    end
  end

  // ----------------------------------------------------------------
  // registered results
  // ----------------------------------------------------------------

  // one-clock completion strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= i_issue;
    end
  end

  // per-instruction timing, held until the next issue
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_head <= 4'h0;
      o_tail <= 10'sh000;
      o_cycles <= 10'h000;
      o_overlap <= 4'h0;
      o_attributed <= 10'h000;
      o_reads <= 4'h0;
      o_fetches <= 4'h0;
      o_writes <= 4'h0;
    end else if (i_issue) begin
      o_head <= next_head[3:0];
      o_tail <= next_tail;
      o_cycles <= next_cyc;
      o_overlap <= next_overlap[3:0];
      o_attributed <= 10'(next_cyc - next_overlap);
      o_reads <= next_reads;
      o_fetches <= next_fetches;
      o_writes <= op_wr;
    end
  end

  // prefetch placement flags
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_spare_clks <= 4'h0;
      o_prefetch_early <= 1'b0;
      o_prefetch_deferred <= 1'b0;
      o_ext_wait <= 1'b0;
      o_queue_words <= `IPO_QUEUE_RESET;
    end else if (i_issue) begin
      o_spare_clks <= next_spare;
      o_prefetch_early <= next_early;
      o_prefetch_deferred <= next_deferred;
      o_ext_wait <= next_ext_wait;
      o_queue_words <= next_queue;
    end
  end

  // running totals; they wrap silently, software is expected to sample often
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_total_clks <= 16'h0000;
      o_total_reads <= 16'h0000;
      o_total_fetches <= 16'h0000;
      o_total_writes <= 16'h0000;
    end else if (i_issue) begin
      o_total_clks <= o_total_clks + 16'(next_cyc - next_overlap);
      o_total_reads <= o_total_reads + 16'(next_reads);
      o_total_fetches <= o_total_fetches + 16'(next_fetches);
      o_total_writes <= o_total_writes + 16'(op_wr);
    end
  end

endmodule

`default_nettype wire

// *** verif/ipo_mem_model.sv ***
// Purpose: far-side synchronous memory seen as clocks per bus access
// Assumes: bench sets the wait states between instructions
// Notes: access length is all the timing block can see of the memory
`timescale 1ns/10ps
`default_nettype none

module ipo_mem_model (
  input wire logic [3:0] i_wait_states,
  output logic [3:0] o_bus_clks
);
  // two-clock access plus wait states; slow memory only stretches it
  assign o_bus_clks = 4'h2 + i_wait_states;
endmodule

`default_nettype wire

// *** verif/ipo_timing_sva.sv ***
// Purpose: port-level checks of the overlap and prefetch timing block
// Assumes: one clock, async active-low reset
// Notes: prev_tail mirrors the tail that the last result left behind
`timescale 1ns/10ps
`default_nettype none

module ipo_timing_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_issue,
  input wire logic [3:0] i_operand_location,
  input wire logic [1:0] i_size,
  input wire logic [3:0] i_op_head,
  input wire logic [1:0] i_op_reads,
  input wire logic i_change_of_flow,
  input wire logic i_taken,
  input wire logic [3:0] i_bus_clks,
  input wire logic o_done,
  input wire logic [3:0] o_head,
  input wire logic signed [9:0] o_tail,
  input wire logic [9:0] o_cycles,
  input wire logic [3:0] o_overlap,
  input wire logic [9:0] o_attributed,
  input wire logic [3:0] o_reads,
  input wire logic [3:0] o_fetches,
  input wire logic [3:0] o_spare_clks,
  input wire logic o_prefetch_early,
  input wire logic o_prefetch_deferred,
  input wire logic o_ext_wait,
  input wire logic [1:0] o_queue_words,
  input wire logic [15:0] o_total_fetches
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic signed [9:0] prev_tail;
  logic signed [9:0] head_s;
  // signed copy of head so tail comparisons stay signed
  assign head_s = {6'h00, o_head};
  // tail as it stood before each edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_tail <= 10'sh000;
    end else begin
      prev_tail <= o_tail;
    end
  end
  a_done_pulse: assert property (i_issue |=> o_done) else $error("no result after issue");
  a_hold_idle: assert property (!i_issue |=> !o_done && $stable(o_total_fetches))
    else $error("result moved without issue");
  a_attrib_sum: assert property (o_done |-> o_attributed == o_cycles - {6'h00, o_overlap})
    else $error("attributed time wrong");
  a_overlap_min: assert property (o_done |-> o_overlap == ((prev_tail <= 0) ? 4'h0 :
    ((prev_tail < head_s) ? prev_tail[3:0] : o_head)))
    else $error("overlap not min of tail and head");
  a_early_neg: assert property (o_done |-> o_prefetch_early == (prev_tail < 0))
    else $error("early prefetch flag wrong");
  a_defer_full: assert property (o_done |-> o_prefetch_deferred ==
    (prev_tail > 0 && prev_tail >= head_s))
    else $error("deferred prefetch flag wrong");
  a_spare_two: assert property (i_issue |=> o_spare_clks ==
    (($past(i_change_of_flow) && $past(i_bus_clks) == 4'h2) ? 4'h2 : 4'h0))
    else $error("spare clocks wrong");
  a_taken_three: assert property (i_issue && i_taken |=> o_fetches >= 4'h3)
    else $error("taken branch under three fetches");
  a_queue_floor: assert property (o_queue_words >= 2'h2)
    else $error("queue below two words");
  a_regdir_free: assert property (i_issue && (i_operand_location ==
    ipo_pkg::IPO_DATA_REGISTER_DIRECT ||
    i_operand_location == ipo_pkg::IPO_ADDRESS_REGISTER_DIRECT)
    |=> o_head == $past(i_op_head) && o_reads == {2'h0, $past(i_op_reads)})
    else $error("register operand cost extra");
  a_index_head: assert property (i_issue && i_operand_location == ipo_pkg::IPO_INDEX8
    |=> o_head == 4'h4)
    else $error("indexed head not four");
  a_long_two: assert property (i_issue && i_operand_location == ipo_pkg::IPO_INDEX8 &&
    i_size == ipo_pkg::IPO_SIZE_LONG && i_op_reads == 2'h0 |=> o_reads == 4'h2)
    else $error("long read not two cycles");
  c_taken: cover property (i_issue && i_taken);
  c_overlap: cover property (o_done && o_overlap != 4'h0);
  c_ext: cover property (o_done && o_ext_wait);
endmodule

bind ipo_timing ipo_timing_sva i_ipo_timing_sva (.i_clk, .i_rst_n, .i_issue, .i_operand_location,
  .i_size, .i_op_head, .i_op_reads, .i_change_of_flow, .i_taken, .i_bus_clks, .o_done, .o_head,
  .o_tail, .o_cycles, .o_overlap, .o_attributed, .o_reads, .o_fetches, .o_spare_clks,
  .o_prefetch_early, .o_prefetch_deferred, .o_ext_wait, .o_queue_words, .o_total_fetches);

`default_nettype wire

// *** verif/ipo_timing_tb.sv ***
// Purpose: directed scenarios for the overlap and prefetch timing block
// Assumes: memory model supplies clocks per access
// Notes: each scenario resets so prior tails do not leak in
`timescale 1ns/10ps
`default_nettype none

module ipo_timing_tb;
  logic i_clk = 1'b0;
  logic i_rst_n, i_issue, i_change_of_flow, i_taken, i_needs_ext, o_done;
  logic [3:0] i_operand_location, i_op_head, i_bus_clks, wait_states;
  logic [1:0] i_size, i_op_reads, i_op_fetches, i_op_writes, o_queue_words;
  logic signed [4:0] i_op_tail;
  logic [5:0] i_op_cycles;
  logic [3:0] o_head, o_overlap, o_reads, o_fetches, o_writes, o_spare_clks;
  logic signed [9:0] o_tail;
  logic [9:0] o_cycles, o_attributed;
  logic o_prefetch_early, o_prefetch_deferred, o_ext_wait;
  logic [15:0] o_total_clks, o_total_reads, o_total_fetches, o_total_writes;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;

  ipo_timing i_ipo_timing (.i_clk, .i_rst_n, .i_issue, .i_operand_location, .i_size, .i_op_head,
    .i_op_tail, .i_op_cycles, .i_op_reads, .i_op_fetches, .i_op_writes, .i_change_of_flow,
    .i_taken, .i_needs_ext, .i_bus_clks, .o_done, .o_head, .o_tail, .o_cycles, .o_overlap,
    .o_attributed, .o_reads, .o_fetches, .o_writes, .o_spare_clks, .o_prefetch_early,
    .o_prefetch_deferred, .o_ext_wait, .o_queue_words, .o_total_clks, .o_total_reads,
    .o_total_fetches, .o_total_writes);
  ipo_mem_model i_ipo_mem_model (.i_wait_states(wait_states), .o_bus_clks(i_bus_clks));

  // ----------------------------------------------------------------
  // clock, watchdog, shared tasks
  // ----------------------------------------------------------------
  always #50 i_clk = ~i_clk;
  // cap well above the roughly 72 cycles the scenarios need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic signed [15:0] got, input logic signed [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %0d exp %0d", $time, got, exp);
    end
  endtask
  task automatic rst();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  // one descriptor, result checked after the answering edge settles
  task automatic drv(input logic [3:0] loc, input logic [1:0] sz, input logic [3:0] h,
    input logic signed [4:0] t, input logic [5:0] c, input logic [1:0] r, f, w,
    input logic cof, tk, ext);
    @(posedge i_clk);
    i_issue <= 1'b1;
    i_operand_location <= loc;
    i_size <= sz;
    i_op_head <= h;
    i_op_tail <= t;
    i_op_cycles <= c;
    i_op_reads <= r;
    i_op_fetches <= f;
    i_op_writes <= w;
    i_change_of_flow <= cof;
    i_taken <= tk;
    i_needs_ext <= ext;
    @(posedge i_clk);
    i_issue <= 1'b0;
    #1;
    chk(o_done, 1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_index8();
    rst();
    drv(ipo_pkg::IPO_INDEX8, ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 0);
    chk(o_head, 4);
    chk(o_cycles, 10);
    chk(o_reads, 1);
    chk(o_fetches, 2);
    chk(o_attributed, 10);
    drv(ipo_pkg::IPO_INDEX8, ipo_pkg::IPO_SIZE_LONG, 0, 0, 2, 0, 1, 0, 0, 0, 0);
    chk(o_cycles, 12);
    chk(o_reads, 2);
    chk(o_total_reads, 3);
  endtask
  task automatic t_overlap();
    rst();
    // word-size table figures in; the long write doubles the writes and adds two clocks inside the block
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_LONG, 0, 2, 4, 0, 1, 1, 0, 0, 0);
    chk(o_head, 0);
    chk(o_writes, 2);
    chk(o_cycles, 6);
    chk(o_tail, 4);
    chk(o_queue_words, 2);
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_LONG, 4, 0, 6, 0, 1, 0, 0, 0, 0);
    chk(o_overlap, 4);
    chk(o_attributed, 2);
    chk(o_prefetch_deferred, 1);
    chk(o_queue_words, 3);
    chk(o_total_writes, 2);
    chk(o_total_fetches, 2);
    chk(o_total_clks, 8);
  endtask
  task automatic t_ext();
    rst();
    drv(ipo_pkg::IPO_IMM_LONG, ipo_pkg::IPO_SIZE_LONG, 0, 0, 2, 0, 1, 0, 0, 0, 0);
    chk(o_ext_wait, 0);
    chk(o_cycles, 7);
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 0, 4, 4, 0, 1, 1, 0, 0, 0);
    drv(ipo_pkg::IPO_IMM_WORD, ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 0);
    chk(o_cycles, 6);
    drv(ipo_pkg::IPO_IMM_WORD, ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 0);
    chk(o_ext_wait, 0);
    chk(o_cycles, 5);
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 0, 4, 4, 0, 1, 1, 0, 0, 0);
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 1);
    chk(o_ext_wait, 1);
    chk(o_cycles, 3);
  endtask
  task automatic t_branch();
    int bl[3] = '{2, 4, 5};
    int b;
    rst();
    for (int k = 0; k < 3; k++) begin
      b = bl[k];
      @(posedge i_clk);
      wait_states <= 4'(b - 2);
      drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 2, -2, 6, 0, 2, 0, 1, 1, 0);
      chk(o_fetches, 3);
      chk(o_tail, b - 4);
      chk(o_cycles, 5 + b + ((b > 4) ? b - 4 : 0));
      chk(o_spare_clks, (b == 2) ? 2 : 0);
      chk(o_queue_words, (b == 2) ? 3 : 2);
      drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 0);
      chk(o_prefetch_early, b == 2);
      chk(o_cycles, b);
    end
    @(posedge i_clk);
    wait_states <= 4'h0;
    drv(ipo_pkg::IPO_DATA_REGISTER_DIRECT, ipo_pkg::IPO_SIZE_WORD, 2, -2, 6, 0, 2, 0, 1, 0, 0);
    chk(o_fetches, 2);
    chk(o_cycles, 6);
  endtask
  // remaining fetch modes, word size; queue runs full so no extension wait
  task automatic t_modes();
    ipo_pkg::ipo_operand_location_t m[8] = '{ipo_pkg::IPO_ADDRESS_REGISTER_DIRECT,
      ipo_pkg::IPO_IND, ipo_pkg::IPO_POSTINC, ipo_pkg::IPO_PREDEC, ipo_pkg::IPO_DISP16,
      ipo_pkg::IPO_ABS_WORD, ipo_pkg::IPO_ABS_LONG, ipo_pkg::IPO_IMM_BYTE};
    int e[8][4] = '{'{0, 2, 0, 1}, '{1, 5, 1, 1}, '{1, 5, 1, 1}, '{2, 6, 1, 1},
      '{1, 7, 1, 2}, '{1, 7, 1, 2}, '{1, 9, 1, 3}, '{1, 5, 0, 2}};
    rst();
    for (int k = 0; k < 8; k++) begin
      drv(m[k], ipo_pkg::IPO_SIZE_WORD, 0, 0, 2, 0, 1, 0, 0, 0, 0);
      chk(o_head, e[k][0]);
      chk(o_cycles, e[k][1]);
      chk(o_reads, e[k][2]);
      chk(o_fetches, e[k][3]);
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_issue, i_change_of_flow, i_taken, i_needs_ext} = 4'h0;
    {i_operand_location, i_op_head, wait_states} = 12'h000;
    {i_size, i_op_reads, i_op_fetches, i_op_writes} = 8'h00;
    i_op_tail = 5'sh00;
    i_op_cycles = 6'h00;
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_index8();
    t_overlap();
    t_ext();
    t_branch();
    t_modes();
    finish_test();
  end
endmodule

`default_nettype wire
